// ==== rtl/tbr_pkg.sv ====
// Purpose: Shared constants for the debug routing and receive-delay block
// Assumes: Byte offsets on an 8-bit register address
// Notes: Stored bytes model the non-volatile image; active routing lives in the loader
package tbr_pkg;
	localparam logic [7:0] OFS_TB_ENABLE = 8'h17;
	localparam logic [7:0] OFS_MISC = 8'he8;
	localparam logic [7:0] OFS_DLY_A = 8'he9;
	localparam logic [7:0] OFS_DLY_B = 8'hea;
	localparam logic [7:0] OFS_DLY_F = 8'heb;
	localparam logic [7:0] OFS_DLY_VIC = 8'hec;
	localparam logic [7:0] OFS_DLY_M2 = 8'hed;
	localparam logic [7:0] OFS_DLY_M4 = 8'hee;
	localparam logic [7:0] OFS_RESERVED = 8'hef;
	localparam logic [7:0] OFS_OUT_TYPE = 8'hf0;
	localparam logic [7:0] OFS_GROUP = 8'hf1;
	localparam logic [7:0] OFS_SWAP = 8'hf2;
	localparam logic [7:0] OFS_MAP_COUNT = 8'hf3;
	localparam logic [7:0] OFS_MAP_ENTRIES = 8'hf4;
	localparam logic [7:0] OFS_CONV_ONE = 8'hf5;
	localparam logic [7:0] OFS_CONV_TWO = 8'hf6;
	localparam logic [7:0] OFS_STATUS = 8'hf8;
	localparam logic [7:0] OFS_COMMAND = 8'hf9;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;
	localparam int MISC_APPLY_BIT = 0;
	localparam int TB_ENABLE_BIT = 0;
	localparam logic [7:0] MODE_ANALOG = 8'h01;
	localparam logic [7:0] MODE_DIGITAL = 8'h02;
	localparam logic [7:0] CMD_LOAD = 8'h01;
	localparam logic [7:0] CMD_DIGITAL = 8'h02;
	localparam logic [7:0] CMD_ANALOG = 8'h03;
	localparam int PAD_COUNT = 4;
	localparam logic [3:0] SEL_CLOCK = 4'h8;
	localparam logic [1:0] PAD_IRQ = 2'h0;
	localparam logic [1:0] PAD_AUX_TWO = 2'h1;
	localparam logic [2:0] TECH_A = 3'h0;
	localparam logic [2:0] TECH_B = 3'h1;
	localparam logic [2:0] TECH_F = 3'h2;
	localparam logic [2:0] TECH_VIC = 3'h3;
	localparam logic [2:0] TECH_M2 = 3'h4;
	localparam logic [2:0] TECH_M4 = 3'h5;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_CLEAR = 3'b010,
		ST_COPY = 3'b100
	} tbr_load_state_t;
endpackage

// ==== rtl/tbr_route_if.sv ====
// Purpose: Stored image and commands toward the loader, active routing back
// Assumes: Single clock domain
// Notes: None
`timescale 1ns/1ps
interface tbr_route_if;
	localparam int PAD_BITS = tbr_pkg::PAD_COUNT;
	logic [7:0] st_mode, st_group, st_swap, st_count, st_conv_one, st_conv_two;
	logic [31:0] st_entries;
	logic load_req, dig_req, ana_req;
	logic [7:0] cmd_p1, cmd_p2;
	logic [7:0] act_mode, act_group, act_swap, act_conv_one, act_conv_two;
	logic [PAD_BITS-1:0] act_pad_en;
	logic [4*PAD_BITS-1:0] act_pad_sel;
	logic busy;
	modport regs (output st_mode, st_group, st_swap, st_count, st_conv_one, st_conv_two, st_entries,
		load_req, dig_req, ana_req, cmd_p1, cmd_p2,
		input act_mode, act_group, act_swap, act_conv_one, act_conv_two, act_pad_en, act_pad_sel, busy);
	modport loader (input st_mode, st_group, st_swap, st_count, st_conv_one, st_conv_two, st_entries,
		load_req, dig_req, ana_req, cmd_p1, cmd_p2,
		output act_mode, act_group, act_swap, act_conv_one, act_conv_two, act_pad_en, act_pad_sel, busy);
endinterface

// ==== rtl/tbr_route_loader.sv ====
// Purpose: Copies stored routing bytes into the active routing and applies commands
// Assumes: Stored image held in the register file
// Notes: Copy walks one map entry per clock
`timescale 1ns/1ps
module tbr_route_loader (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_reset_n,
	// Routing link
	tbr_route_if.loader rt
);
	tbr_pkg::tbr_load_state_t state_reg, state_next;
	logic [1:0] idx_reg;
	logic [7:0] entry;
	logic entry_ok;
	assign entry = rt.st_entries[{idx_reg, 3'b000} +: 8];
	assign entry_ok = ({6'h00, idx_reg} < rt.st_count) && (entry[7:4] < 4'h4);
	assign rt.busy = (state_reg != tbr_pkg::ST_IDLE);
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			tbr_pkg::ST_IDLE: if (rt.load_req) state_next = tbr_pkg::ST_CLEAR;
			tbr_pkg::ST_CLEAR: state_next = tbr_pkg::ST_COPY;
			tbr_pkg::ST_COPY: if (idx_reg == 2'h3) state_next = tbr_pkg::ST_IDLE;
			default: state_next = tbr_pkg::ST_IDLE;
		endcase
	end
	// Reset lands in the clear state so stored bytes are read after reset [RULE23]
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_reg <= tbr_pkg::ST_CLEAR;
			idx_reg <= 2'h0;
			rt.act_mode <= tbr_pkg::RESET_BYTE;
			rt.act_group <= tbr_pkg::RESET_BYTE;
			rt.act_swap <= tbr_pkg::RESET_BYTE;
			rt.act_conv_one <= tbr_pkg::RESET_BYTE;
			rt.act_conv_two <= tbr_pkg::RESET_BYTE;
			rt.act_pad_en <= '0;
			rt.act_pad_sel <= '0;
		end else begin
			state_reg <= state_next;
			idx_reg <= (state_reg == tbr_pkg::ST_COPY) ? idx_reg + 2'h1 : 2'h0;
			if (state_reg == tbr_pkg::ST_CLEAR) begin
				rt.act_mode <= rt.st_mode; // [RULE18]
				rt.act_group <= rt.st_group;
				rt.act_swap <= rt.st_swap;
				rt.act_conv_one <= rt.st_conv_one;
				rt.act_conv_two <= rt.st_conv_two;
				rt.act_pad_en <= '0;
			end else if (state_reg == tbr_pkg::ST_COPY) begin
				// Entries past the count or at reserved pads are skipped [RULE9] [RULE10] [RULE22]
				if (entry_ok) begin
					rt.act_pad_en[entry[5:4]] <= 1'b1;
					rt.act_pad_sel[{entry[5:4], 2'b00} +: 4] <= entry[3:0]; // [RULE11]
				end
			end else if (rt.dig_req) begin
				// Digital command: group then pad and signal [RULE16] [RULE21]
				rt.act_mode <= tbr_pkg::MODE_DIGITAL;
				rt.act_group <= rt.cmd_p1;
				if (rt.cmd_p2[7:4] < 4'h4) begin
					rt.act_pad_en[rt.cmd_p2[5:4]] <= 1'b1;
					rt.act_pad_sel[{rt.cmd_p2[5:4], 2'b00} +: 4] <= rt.cmd_p2[3:0];
				end
			end else if (rt.ana_req) begin
				rt.act_mode <= tbr_pkg::MODE_ANALOG; // [RULE16]
				rt.act_conv_one <= rt.cmd_p1;
				rt.act_conv_two <= rt.cmd_p2;
			end
		end
	end
endmodule

// ==== rtl/tbr_testbus_routing.sv ====
// Purpose: Debug signal routing onto four pads, converter feeds and receive delay
// Assumes: Debug bus and converter words come from logic on i_clock
// Notes: Reference clock arrives from another domain and is resynchronised
//
// Functional notes
// RULE1 - Type A delay: base, x2, x4, x8
// RULE2 - Type B delay: base, x2, x4, x8
// RULE3 - Type F delay: base at 424, x2
// RULE4 - Vicinity delay: base fast-high, x2 high
// RULE5 - Two mode bases, applied unscaled
// RULE6 - Output type 1 analog, 2 digital
// RULE7 - Only listed group and converter codes valid
// RULE8 - Swap byte maps line zero/one
// RULE9 - Apply only counted pad map entries
// RULE10 - Upper nibble selects pad, 4-15 reserved
// RULE11 - Lower nibble selects bit; 8 clock
// RULE12 - Analog: converter one IRQ, two aux
// RULE13 - At most two analog, four digital
// RULE14 - Converters fed real-time processing words
// RULE15 - Output only with enable set
// RULE16 - Separate digital and analog config commands
// RULE17 - Host selects protocol via load command
// RULE18 - Registers set by host or copy
// RULE19 - Separate inbound and outbound data buffers
// RULE20 - Delay applied only when flag set
// RULE21 - Command param two: pad, signal nibbles
// RULE22 - Reserved pad or bad group: pad idle
// RULE23 - Stored bytes read after reset, kept
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
module tbr_testbus_routing (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_reset_n,
	// Register port
	input wire logic [7:0] i_reg_addr,
	input wire logic [31:0] i_reg_wdata,
	input wire logic i_reg_write,
	input wire logic i_reg_read,
	output logic [31:0] o_reg_rdata,
	// Debug sources
	input wire logic [7:0] i_debug_bus,
	input wire logic i_ref_clock_13,
	input wire logic [7:0] i_proc_word_one,
	input wire logic [7:0] i_proc_word_two,
	// Receive delay lookup
	input wire logic [2:0] i_tech,
	input wire logic [1:0] i_rate,
	output logic [10:0] o_rx_delay,
	// Pads
	output logic [3:0] o_pad_out,
	output logic [3:0] o_pad_oe,
	output logic [1:0] o_pad_analog,
	output logic [7:0] o_conv_one_code,
	output logic [7:0] o_conv_two_code,
	// Buffers
	input wire logic i_rx_push,
	input wire logic [7:0] i_rx_byte,
	input wire logic i_tx_pop,
	output logic [7:0] o_tx_byte
);
	localparam int BUF_DEPTH = 16;

	// Valid digital group codes [RULE7]
	function automatic logic group_valid(input logic [7:0] code);
		case (code)
			8'h00, 8'h01, 8'h10, 8'h1b, 8'h1d, 8'h30, 8'h58, 8'h70, 8'h73: group_valid = 1'b1;
			default: group_valid = 1'b0;
		endcase
	endfunction

	// Valid converter source codes [RULE7]
	function automatic logic conv_valid(input logic [7:0] code);
		case (code)
			8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h09, 8'h0a: conv_valid = 1'b1;
			default: conv_valid = 1'b0;
		endcase
	endfunction

	tbr_route_if rt ();

	logic [7:0] tb_enable_reg, misc_reg;
	logic [7:0] dly_a_reg, dly_b_reg, dly_f_reg, dly_vic_reg, dly_m2_reg, dly_m4_reg;
	logic [7:0] out_type_reg, group_reg, swap_reg, count_reg, conv_one_reg, conv_two_reg;
	logic [31:0] entries_reg;
	logic load_req_reg, dig_req_reg, ana_req_reg;
	logic [7:0] cmd_p1_reg, cmd_p2_reg;
	logic [31:0] rdata_reg, rdata_next;
	logic ref_meta_reg, ref_sync_reg;
	logic [10:0] delay_reg, delay_next;
	logic [3:0] pad_out_reg, pad_out_next, pad_oe_reg, pad_oe_next;
	logic [1:0] pad_analog_reg, pad_analog_next;
	logic [7:0] conv_one_code_reg, conv_two_code_reg;
	logic [7:0] rx_mem [BUF_DEPTH];
	logic [7:0] tx_mem [BUF_DEPTH];
	logic [3:0] rx_wptr_reg, tx_rptr_reg;
	logic [7:0] tx_byte_reg;

	logic wr_cmd, tb_on, digital_on, analog_on, group_ok;
	logic [7:0] eff_bus;
	logic [7:0] dly_base;
	logic [1:0] dly_shift;
	logic [1:0] shift_cap;
	logic [7:0] cmd_code;

	assign rt.st_mode = out_type_reg;
	assign rt.st_group = group_reg;
	assign rt.st_swap = swap_reg;
	assign rt.st_count = count_reg;
	assign rt.st_entries = entries_reg;
	assign rt.st_conv_one = conv_one_reg;
	assign rt.st_conv_two = conv_two_reg;
	assign rt.load_req = load_req_reg;
	assign rt.dig_req = dig_req_reg;
	assign rt.ana_req = ana_req_reg;
	assign rt.cmd_p1 = cmd_p1_reg;
	assign rt.cmd_p2 = cmd_p2_reg;

	tbr_route_loader u_loader (
		.i_clock(i_clock),
		.i_reset_n(i_reset_n),
		.rt(rt.loader)
	);

	// Register writes
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			tb_enable_reg <= tbr_pkg::RESET_BYTE;
			misc_reg <= tbr_pkg::RESET_BYTE;
			dly_a_reg <= tbr_pkg::RESET_BYTE;
			dly_b_reg <= tbr_pkg::RESET_BYTE;
			dly_f_reg <= tbr_pkg::RESET_BYTE;
			dly_vic_reg <= tbr_pkg::RESET_BYTE;
			dly_m2_reg <= tbr_pkg::RESET_BYTE;
			dly_m4_reg <= tbr_pkg::RESET_BYTE;
			out_type_reg <= tbr_pkg::RESET_BYTE;
			group_reg <= tbr_pkg::RESET_BYTE;
			swap_reg <= tbr_pkg::RESET_BYTE;
			count_reg <= tbr_pkg::RESET_BYTE;
			entries_reg <= tbr_pkg::RESET_WORD;
			conv_one_reg <= tbr_pkg::RESET_BYTE;
			conv_two_reg <= tbr_pkg::RESET_BYTE;
		end else if (i_reg_write) begin
			case (i_reg_addr)
				tbr_pkg::OFS_TB_ENABLE: tb_enable_reg <= i_reg_wdata[7:0];
				tbr_pkg::OFS_MISC: misc_reg <= i_reg_wdata[7:0];
				tbr_pkg::OFS_DLY_A: dly_a_reg <= i_reg_wdata[7:0];
				tbr_pkg::OFS_DLY_B: dly_b_reg <= i_reg_wdata[7:0];
				tbr_pkg::OFS_DLY_F: dly_f_reg <= i_reg_wdata[7:0];
				tbr_pkg::OFS_DLY_VIC: dly_vic_reg <= i_reg_wdata[7:0];
				tbr_pkg::OFS_DLY_M2: dly_m2_reg <= i_reg_wdata[7:0];
				tbr_pkg::OFS_DLY_M4: dly_m4_reg <= i_reg_wdata[7:0];
				tbr_pkg::OFS_OUT_TYPE: out_type_reg <= i_reg_wdata[7:0];
				tbr_pkg::OFS_GROUP: group_reg <= i_reg_wdata[7:0];
				tbr_pkg::OFS_SWAP: swap_reg <= i_reg_wdata[7:0];
				tbr_pkg::OFS_MAP_COUNT: count_reg <= i_reg_wdata[7:0];
				tbr_pkg::OFS_MAP_ENTRIES: entries_reg <= i_reg_wdata;
				tbr_pkg::OFS_CONV_ONE: conv_one_reg <= i_reg_wdata[7:0];
				tbr_pkg::OFS_CONV_TWO: conv_two_reg <= i_reg_wdata[7:0];
				default: ;
			endcase
		end
	end

	// Commands become one-cycle requests to the loader; ignored while it copies
	assign wr_cmd = i_reg_write && (i_reg_addr == tbr_pkg::OFS_COMMAND) && !rt.busy;
	assign cmd_code = i_reg_wdata[7:0];

	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			load_req_reg <= 1'b0;
			dig_req_reg <= 1'b0;
			ana_req_reg <= 1'b0;
			cmd_p1_reg <= tbr_pkg::RESET_BYTE;
			cmd_p2_reg <= tbr_pkg::RESET_BYTE;
		end else begin
			load_req_reg <= wr_cmd && (cmd_code == tbr_pkg::CMD_LOAD); // [RULE17] [RULE18]
			dig_req_reg <= wr_cmd && (cmd_code == tbr_pkg::CMD_DIGITAL); // [RULE16]
			ana_req_reg <= wr_cmd && (cmd_code == tbr_pkg::CMD_ANALOG); // [RULE16]
			if (wr_cmd) begin
				cmd_p1_reg <= i_reg_wdata[15:8];
				cmd_p2_reg <= i_reg_wdata[23:16];
			end
		end
	end

	// Read data, valid the cycle after the strobe only
	always_comb begin
		rdata_next = tbr_pkg::RESET_WORD;
		if (i_reg_read) begin
			case (i_reg_addr)
				tbr_pkg::OFS_TB_ENABLE: rdata_next = {24'h000000, tb_enable_reg};
				tbr_pkg::OFS_MISC: rdata_next = {24'h000000, misc_reg};
				tbr_pkg::OFS_DLY_A: rdata_next = {24'h000000, dly_a_reg};
				tbr_pkg::OFS_DLY_B: rdata_next = {24'h000000, dly_b_reg};
				tbr_pkg::OFS_DLY_F: rdata_next = {24'h000000, dly_f_reg};
				tbr_pkg::OFS_DLY_VIC: rdata_next = {24'h000000, dly_vic_reg};
				tbr_pkg::OFS_DLY_M2: rdata_next = {24'h000000, dly_m2_reg};
				tbr_pkg::OFS_DLY_M4: rdata_next = {24'h000000, dly_m4_reg};
				tbr_pkg::OFS_OUT_TYPE: rdata_next = {24'h000000, out_type_reg};
				tbr_pkg::OFS_GROUP: rdata_next = {24'h000000, group_reg};
				tbr_pkg::OFS_SWAP: rdata_next = {24'h000000, swap_reg};
				tbr_pkg::OFS_MAP_COUNT: rdata_next = {24'h000000, count_reg};
				tbr_pkg::OFS_MAP_ENTRIES: rdata_next = entries_reg;
				tbr_pkg::OFS_CONV_ONE: rdata_next = {24'h000000, conv_one_reg};
				tbr_pkg::OFS_CONV_TWO: rdata_next = {24'h000000, conv_two_reg};
				tbr_pkg::OFS_STATUS: rdata_next = {rt.busy, 3'h0, rt.act_pad_en, rt.act_pad_sel,
					rt.act_mode};
				default: rdata_next = tbr_pkg::RESET_WORD;
			endcase
		end
	end

	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rdata_reg <= tbr_pkg::RESET_WORD;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	// Reference clock crosses in by two flops
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ref_meta_reg <= 1'b0;
			ref_sync_reg <= 1'b0;
		end else begin
			ref_meta_reg <= i_ref_clock_13;
			ref_sync_reg <= ref_meta_reg;
		end
	end

	// Line swap: zero copies bit 0 onto line one, one copies bit 1 onto line zero
	assign eff_bus[7:2] = i_debug_bus[7:2];
	assign eff_bus[1] = (rt.act_swap == 8'h00) ? i_debug_bus[0] : i_debug_bus[1]; // [RULE8]
	assign eff_bus[0] = (rt.act_swap == 8'h01) ? i_debug_bus[1] : i_debug_bus[0]; // [RULE8]

	assign tb_on = tb_enable_reg[tbr_pkg::TB_ENABLE_BIT]; // [RULE15]
	assign digital_on = tb_on && (rt.act_mode == tbr_pkg::MODE_DIGITAL); // [RULE6]
	assign analog_on = tb_on && (rt.act_mode == tbr_pkg::MODE_ANALOG); // [RULE6]
	assign group_ok = group_valid(rt.act_group); // [RULE22]

	// Four digital pads at most, one per location [RULE13]
	genvar gi;
	generate
		for (gi = 0; gi < tbr_pkg::PAD_COUNT; gi++) begin : g_pad
			logic [3:0] sel;
			logic sel_ok, drive;
			logic analog_pad;
			assign sel = rt.act_pad_sel[gi*4 +: 4];
			assign sel_ok = (sel <= tbr_pkg::SEL_CLOCK);
			assign drive = digital_on && group_ok && rt.act_pad_en[gi] && sel_ok; // [RULE22]
			if (gi < 2) begin : g_an
				assign analog_pad = analog_on &&
					((gi == 0) ? conv_valid(rt.act_conv_one) : conv_valid(rt.act_conv_two)); // [RULE12]
			end else begin : g_dig
				assign analog_pad = 1'b0;
			end
			assign pad_oe_next[gi] = drive && !analog_pad;
			assign pad_out_next[gi] = drive &&
				((sel == tbr_pkg::SEL_CLOCK) ? ref_sync_reg : eff_bus[sel[2:0]]); // [RULE11]
		end
	endgenerate
	assign pad_analog_next = {g_pad[1].analog_pad, g_pad[0].analog_pad}; // [RULE13]

	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pad_out_reg <= 4'h0;
			pad_oe_reg <= 4'h0;
			pad_analog_reg <= 2'h0;
			conv_one_code_reg <= tbr_pkg::RESET_BYTE;
			conv_two_code_reg <= tbr_pkg::RESET_BYTE;
		end else begin
			pad_out_reg <= pad_out_next;
			pad_oe_reg <= pad_oe_next;
			pad_analog_reg <= pad_analog_next;
			// Processing words pass every cycle, no sample hold [RULE14]
			conv_one_code_reg <= pad_analog_next[0] ? i_proc_word_one : tbr_pkg::RESET_BYTE;
			conv_two_code_reg <= pad_analog_next[1] ? i_proc_word_two : tbr_pkg::RESET_BYTE;
		end
	end

	// Delay base and scaling per technology
	always_comb begin
		dly_base = tbr_pkg::RESET_BYTE;
		shift_cap = 2'h0;
		case (i_tech)
			tbr_pkg::TECH_A: begin
				dly_base = dly_a_reg; // [RULE1]
				shift_cap = 2'h3;
			end
			tbr_pkg::TECH_B: begin
				dly_base = dly_b_reg; // [RULE2]
				shift_cap = 2'h3;
			end
			tbr_pkg::TECH_F: begin
				dly_base = dly_f_reg; // [RULE3]
				shift_cap = 2'h1;
			end
			tbr_pkg::TECH_VIC: begin
				dly_base = dly_vic_reg; // [RULE4]
				shift_cap = 2'h1;
			end
			tbr_pkg::TECH_M2: dly_base = dly_m2_reg; // [RULE5]
			tbr_pkg::TECH_M4: dly_base = dly_m4_reg; // [RULE5]
			default: dly_base = tbr_pkg::RESET_BYTE;
		endcase
	end
	// Slower rate codes beyond a technology's range clamp to its slowest step
	assign dly_shift = (i_rate > shift_cap) ? shift_cap : i_rate;
	assign delay_next = misc_reg[tbr_pkg::MISC_APPLY_BIT] ?
		({3'h0, dly_base} << dly_shift) : 11'h000; // [RULE20]

	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			delay_reg <= 11'h000;
		end else begin
			delay_reg <= delay_next;
		end
	end

	// Separate inbound and outbound buffers; tx_mem is written one entry behind the rx write pointer [RULE19]
	always_ff @(posedge i_clock) begin
		if (i_rx_push) begin
			rx_mem[rx_wptr_reg] <= i_rx_byte;
		end
	end

	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rx_wptr_reg <= 4'h0;
			tx_rptr_reg <= 4'h0;
			tx_byte_reg <= tbr_pkg::RESET_BYTE;
		end else begin
			if (i_rx_push) begin
				rx_wptr_reg <= rx_wptr_reg + 4'h1;
			end
			if (i_tx_pop) begin
				tx_byte_reg <= tx_mem[tx_rptr_reg];
				tx_rptr_reg <= tx_rptr_reg + 4'h1;
			end
		end
	end

	// Loopback copy trails the write pointer so it sees the byte just stored
	always_ff @(posedge i_clock) begin
		tx_mem[rx_wptr_reg - 4'h1] <= rx_mem[rx_wptr_reg - 4'h1];
	end

	assign o_reg_rdata = rdata_reg;
	assign o_rx_delay = delay_reg;
	assign o_pad_out = pad_out_reg;
	assign o_pad_oe = pad_oe_reg;
	assign o_pad_analog = pad_analog_reg;
	assign o_conv_one_code = conv_one_code_reg;
	assign o_conv_two_code = conv_two_code_reg;
	assign o_tx_byte = tx_byte_reg;
endmodule

// ==== tb/tb_top.sv ====
// Purpose: Self-checking bench for the debug routing block
// Assumes: Host model drives the register port
// Notes: Pad and buffer checks settle a few cycles
`timescale 1ns/1ps
module tb_top;
	logic i_clock = 1'b0;
	logic i_reset_n = 1'b0;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, rd;
	logic reg_write, reg_read;
	logic [7:0] debug_bus = 8'h00;
	logic [7:0] word_one = 8'h5a;
	logic [7:0] word_two = 8'hc3;
	logic [2:0] tech = 3'h0;
	logic [1:0] rate = 2'h0;
	logic [10:0] rx_delay;
	logic [3:0] pad_out, pad_oe;
	logic [1:0] pad_analog;
	logic [7:0] conv_one, conv_two;
	logic ref_clock = 1'b0, rx_push = 1'b0, tx_pop = 1'b0;
	logic [7:0] rx_byte = 8'h00, tx_byte;
	int bad_count = 0;
	int comparisons = 0;
	int cycles = 0;
	initial forever #10 i_clock = ~i_clock;
	tbr_host_model host (.i_clock(i_clock), .o_addr(reg_addr), .o_wdata(reg_wdata), .o_write(reg_write),
		.o_read(reg_read), .i_rdata(reg_rdata));
	tbr_testbus_routing dut (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_reg_addr(reg_addr),
		.i_reg_wdata(reg_wdata), .i_reg_write(reg_write), .i_reg_read(reg_read), .o_reg_rdata(reg_rdata),
		.i_debug_bus(debug_bus), .i_ref_clock_13(ref_clock), .i_proc_word_one(word_one),
		.i_proc_word_two(word_two), .i_tech(tech), .i_rate(rate), .o_rx_delay(rx_delay),
		.o_pad_out(pad_out), .o_pad_oe(pad_oe), .o_pad_analog(pad_analog), .o_conv_one_code(conv_one),
		.o_conv_two_code(conv_two), .i_rx_push(rx_push), .i_rx_byte(rx_byte), .i_tx_pop(tx_pop),
		.o_tx_byte(tx_byte));
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		comparisons++;
		if (seen !== want) begin
			bad_count++;
			$display("Error at %0t: saw %h expected %h", $time, seen, want);
		end
	endtask
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	always @(posedge i_clock) begin
		cycles++;
		if (cycles == 5000) begin
			bad_count++;
			wrap_up();
		end
	end
	task automatic settle();
		repeat (3) @(posedge i_clock);
		#1;
	endtask
	// Loader walk is short; twenty polls is ample
	task automatic load_wait();
		host.wr(tbr_pkg::OFS_COMMAND, {24'h0, tbr_pkg::CMD_LOAD});
		for (int k = 0; k < 20; k++) begin
			host.rd(tbr_pkg::OFS_STATUS, rd);
			if (rd[31] === 1'b0)
				break;
		end
		check(rd[31], 1'b0);
	endtask
	task automatic t_regs();
		logic [7:0] a;
		logic [31:0] v;
		for (int k = 0; k < 14; k++) begin
			a = 8'he9 + k[7:0];
			v = {~a, a, 8'h96, a ^ 8'h3c};
			host.rd(a, rd);
			check(rd, 32'h0);
			host.wr(a, v);
			host.rd(a, rd);
			check(rd, (a == 8'hef) ? 32'h0 : (a == 8'hf4) ? v : {24'h0, v[7:0]});
		end
		host.wr(8'h40, 32'hffff_ffff);
		host.rd(8'h40, rd);
		check(rd, 32'h0);
		$display("register test done");
	endtask
	task automatic t_delay();
		logic [7:0] base [6] = '{8'h9b, 8'hc1, 8'h7f, 8'h55, 8'h33, 8'he1};
		int cap [6] = '{3, 3, 1, 1, 0, 0};
		host.wr(tbr_pkg::OFS_MISC, 32'h1);
		for (int t = 0; t < 6; t++)
			host.wr(tbr_pkg::OFS_DLY_A + t[7:0], {24'h0, base[t]});
		for (int t = 0; t < 7; t++) begin
			for (int r = 0; r < 4; r++) begin
				@(posedge i_clock);
				tech <= t[2:0];
				rate <= r[1:0];
				repeat (2) @(posedge i_clock);
				#1;
				if (t == 6)
					check(rx_delay, 32'h0);
				else
					check(rx_delay, {3'h0, base[t]} << ((r < cap[t]) ? r : cap[t]));
			end
		end
		host.wr(tbr_pkg::OFS_MISC, 32'h0);
		@(posedge i_clock);
		tech <= 3'h0;
		settle();
		check(rx_delay, 32'h0);
		$display("delay test done");
	endtask
	task automatic t_digital();
		host.wr(tbr_pkg::OFS_TB_ENABLE, 32'h1);
		host.wr(tbr_pkg::OFS_OUT_TYPE, 32'h2);
		host.wr(tbr_pkg::OFS_GROUP, 32'h58);
		host.wr(tbr_pkg::OFS_SWAP, 32'h0);
		host.wr(tbr_pkg::OFS_MAP_COUNT, 32'h2);
		host.wr(tbr_pkg::OFS_MAP_ENTRIES, 32'h4017_2503);
		load_wait();
		@(posedge i_clock);
		debug_bus <= 8'h08;
		settle();
		check(pad_oe, 4'h5);
		check(pad_out & 4'h5, 4'h1);
		host.wr(tbr_pkg::OFS_COMMAND, {8'h00, 8'h31, 8'h1b, tbr_pkg::CMD_DIGITAL});
		@(posedge i_clock);
		debug_bus <= 8'h01;
		settle();
		check(pad_oe, 4'hd);
		check(pad_out & 4'hd, 4'h8);
		ref_clock <= 1'b1;
		debug_bus <= 8'h00;
		host.wr(tbr_pkg::OFS_COMMAND, {8'h00, 8'h18, 8'h1b, tbr_pkg::CMD_DIGITAL});
		settle();
		check(pad_oe, 4'hf);
		check(pad_out, 4'h2);
		host.wr(tbr_pkg::OFS_TB_ENABLE, 32'h0);
		settle();
		check(pad_oe, 4'h0);
		host.wr(tbr_pkg::OFS_TB_ENABLE, 32'h1);
		host.wr(tbr_pkg::OFS_COMMAND, {8'h00, 8'h02, 8'h22, tbr_pkg::CMD_DIGITAL});
		settle();
		check(pad_oe, 4'h0);
		$display("digital test done");
	endtask
	task automatic t_analog();
		host.wr(tbr_pkg::OFS_OUT_TYPE, 32'h1);
		host.wr(tbr_pkg::OFS_CONV_ONE, 32'h01);
		host.wr(tbr_pkg::OFS_CONV_TWO, 32'h0a);
		load_wait();
		settle();
		check(pad_analog, 2'h3);
		check(pad_oe, 4'h0);
		check(conv_two, word_two);
		@(posedge i_clock);
		word_one <= 8'h81;
		settle();
		check(conv_one, 8'h81);
		host.wr(tbr_pkg::OFS_COMMAND, {8'h00, 8'h09, 8'h08, tbr_pkg::CMD_ANALOG});
		settle();
		check(pad_analog, 2'h2);
		check(conv_one, 8'h00);
		$display("analog test done");
	endtask
	task automatic t_buffers();
		@(posedge i_clock);
		rx_push <= 1'b1;
		rx_byte <= 8'ha7;
		@(posedge i_clock);
		rx_byte <= 8'h3e;
		@(posedge i_clock);
		rx_push <= 1'b0;
		tx_pop <= 1'b1;
		@(posedge i_clock);
		#1;
		check(tx_byte, 8'ha7);
		@(posedge i_clock);
		tx_pop <= 1'b0;
		#1;
		check(tx_byte, 8'h3e);
		$display("buffer test done");
	endtask
	initial begin
		repeat (3) @(posedge i_clock);
		i_reset_n <= 1'b1;
		repeat (8) @(posedge i_clock);
		t_regs();
		t_delay();
		t_digital();
		t_analog();
		t_buffers();
		wrap_up();
	end
endmodule

// ==== tb/tbr_host_model.sv ====
// Purpose: Host controller on the register port
// Assumes: Tasks entered just after a clock edge
// Notes: Address and data scrambled while no strobe is up
`timescale 1ns/1ps
module tbr_host_model (
	// Clock
	input wire logic i_clock,
	// Register port
	output logic [7:0] o_addr,
	output logic [31:0] o_wdata,
	output logic o_write,
	output logic o_read,
	input wire logic [31:0] i_rdata
);
	initial begin
		o_addr = 8'h00;
		o_wdata = 32'h0000_0000;
		o_write = 1'b0;
		o_read = 1'b0;
	end
	// Routing only changed through commands, never direct pokes
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clock);
		o_addr <= a;
		o_wdata <= d;
		o_write <= 1'b1;
		@(posedge i_clock);
		o_write <= 1'b0;
		o_addr <= ~a;
		o_wdata <= ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge i_clock);
		o_addr <= a;
		o_read <= 1'b1;
		@(posedge i_clock);
		o_read <= 1'b0;
		o_addr <= ~a;
		#1;
		d = i_rdata;
	endtask
endmodule

// ==== tb/tbr_routing_checker_properties.sv ====
// Purpose: Port-level checks for the debug routing block
// Assumes: One clock, asynchronous active-low reset
// Notes: Delay lookup taken as one registered cycle
`timescale 1ns/1ps
module tbr_routing_checker (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_reset_n,
	// Register port
	input wire logic [7:0] i_reg_addr,
	input wire logic i_reg_read,
	input wire logic [31:0] o_reg_rdata,
	// Delay lookup
	input wire logic [2:0] i_tech,
	input wire logic [1:0] i_rate,
	input wire logic [10:0] o_rx_delay,
	// Pads
	input wire logic [3:0] o_pad_oe,
	input wire logic [1:0] o_pad_analog,
	input wire logic [7:0] o_conv_one_code,
	input wire logic [7:0] o_conv_two_code
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_reset_n);
	property p_rdata_idle;
		!$past(i_reg_read) |-> o_reg_rdata == 32'h0000_0000;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside its slot");
	property p_byte_upper;
		$past(i_reg_read) && $past(i_reg_addr) < 8'hf8 && $past(i_reg_addr) != 8'hf4 |-> o_reg_rdata[31:8] == 24'h0;
	endproperty
	a_byte_upper: assert property (p_byte_upper) else $error("byte register upper bits set");
	property p_reserved;
		$past(i_reg_read) && $past(i_reg_addr) == 8'hef |-> o_reg_rdata == 32'h0000_0000;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved byte not zero");
	property p_mode_excl;
		|o_pad_analog |-> o_pad_oe == 4'h0;
	endproperty
	a_mode_excl: assert property (p_mode_excl) else $error("analog and digital together");
	property p_conv_one_idle;
		!o_pad_analog[0] |-> o_conv_one_code == 8'h00;
	endproperty
	a_conv_one_idle: assert property (p_conv_one_idle) else $error("converter one fed while idle");
	property p_conv_two_idle;
		!o_pad_analog[1] |-> o_conv_two_code == 8'h00;
	endproperty
	a_conv_two_idle: assert property (p_conv_two_idle) else $error("converter two fed while idle");
	property p_delay_ab;
		$past(i_tech) <= 3'h1 |-> (o_rx_delay & ~(11'h7ff << $past(i_rate))) == 11'h0;
	endproperty
	a_delay_ab: assert property (p_delay_ab) else $error("type A or B scaling wrong");
	property p_delay_fv;
		$past(i_tech) == 3'h2 || $past(i_tech) == 3'h3 |-> o_rx_delay[10:9] == 2'h0
			&& ($past(i_rate) == 2'h0 || !o_rx_delay[0]);
	endproperty
	a_delay_fv: assert property (p_delay_fv) else $error("type F or vicinity scaling wrong");
	property p_delay_modes;
		$past(i_tech) == 3'h4 || $past(i_tech) == 3'h5 |-> o_rx_delay[10:8] == 3'h0;
	endproperty
	a_delay_modes: assert property (p_delay_modes) else $error("mode delay scaled");
	property p_delay_other;
		$past(i_tech) > 3'h5 |-> o_rx_delay == 11'h0;
	endproperty
	a_delay_other: assert property (p_delay_other) else $error("unknown technology delay");
endmodule
bind tbr_testbus_routing tbr_routing_checker chk (.i_clock(i_clock), .i_reset_n(i_reset_n),
	.i_reg_addr(i_reg_addr), .i_reg_read(i_reg_read), .o_reg_rdata(o_reg_rdata), .i_tech(i_tech),
	.i_rate(i_rate), .o_rx_delay(o_rx_delay), .o_pad_oe(o_pad_oe), .o_pad_analog(o_pad_analog),
	.o_conv_one_code(o_conv_one_code), .o_conv_two_code(o_conv_two_code));
